// ===== hdl/pgp_defines.vh
`ifndef PGP_DEFINES_VH
`define PGP_DEFINES_VH

`define PGP_CMD_SET 8'h22
`define PGP_CMD_READ 8'h23
`define PGP_RSP_OK 8'h40
`define PGP_RSP_ERR 8'hC0
`define PGP_LEN_SET_VAL 8'h02
`define PGP_LEN_SET_CFG 8'h03
`define PGP_LEN_READ 8'h01
`define PGP_LEN_READ_RSP 8'h04
`define PGP_LEN_NONE 8'h00

`define PGP_NUM_PINS 13
`define PGP_NUM_GPIO 5
`define PGP_IDX_LIMIT 8'h0D
`define PGP_DUTY_HIGH 7'h64
`define PGP_DUTY_MAX 8'h64

`define PGP_CFG_F_BIT 3
`define PGP_MODE_PD 3'h0
`define PGP_MODE_PP 3'h1
`define PGP_MODE_HIZ 3'h2
`define PGP_MODE_PU 3'h3
`define PGP_MODE_SLOW_HI 3'h4
`define PGP_MODE_SLOW_PP 3'h5
`define PGP_MODE_RSVD 3'h6
`define PGP_MODE_SLOW_LO 3'h7

`define PGP_RST_CFG_IN 4'h2
`define PGP_RST_CFG_CTL 4'h1
`define PGP_RST_CFG_LED 4'h1
`define PGP_RST_DUTY 7'h00

`define PGP_CLK_HZ 10000000
`define PGP_SAMPLE_HZ 32
`define PGP_SAMPLE_CYC (`PGP_CLK_HZ / `PGP_SAMPLE_HZ)
`define PGP_PWM_HZ 100
`define PGP_PWM_STEPS 100
`define PGP_PWM_STEP_CYC (`PGP_CLK_HZ / (`PGP_PWM_HZ * `PGP_PWM_STEPS))

`endif

// ===== hdl/pgp_pin_drive.v
`timescale 1ns/1ps
`include "pgp_defines.vh"

module pgp_pin_drive (
    input wire i_sys_clk,
    input wire i_arst_n,
    input wire i_user,
    input wire [2:0] i_mode,
    input wire i_level,
    input wire i_dflt_oe,
    input wire i_dflt_out,
    output reg o_out,
    output reg o_oe,
    output reg o_pull_up,
    output reg o_pull_dn,
    output reg o_slow,
    output reg o_high
);
    reg next_out;
    reg next_oe;
    reg next_pu;
    reg next_pd;
    reg next_slow;

    always @* begin
        next_out = 1'b0;
        next_oe = 1'b0;
        next_pu = 1'b0;
        next_pd = 1'b0;
        next_slow = 1'b0;
        if (!i_user) begin
            // default role owns the pin
            next_oe = i_dflt_oe;
            next_out = i_dflt_out;
        end else begin
            case (i_mode)
                `PGP_MODE_PD: begin
                    next_oe = i_level;
                    next_out = i_level;
                    next_pd = ~i_level;
                end
                `PGP_MODE_PP: begin
                    next_oe = 1'b1;
                    next_out = i_level;
                end
                `PGP_MODE_PU: begin
                    next_oe = ~i_level;
                    next_pu = i_level;
                end
                `PGP_MODE_SLOW_HI: begin
                    next_oe = i_level;
                    next_out = i_level;
                    next_slow = 1'b1;
                end
                `PGP_MODE_SLOW_PP: begin
                    next_oe = 1'b1;
                    next_out = i_level;
                    next_slow = 1'b1;
                end
                `PGP_MODE_SLOW_LO: begin
                    next_oe = ~i_level;
                    next_slow = 1'b1;
                end
                default: begin
                    next_oe = 1'b0; // hi-z input
                end
            endcase
        end
    end

    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_out <= 1'b0;
            o_oe <= 1'b0;
            o_pull_up <= 1'b0;
            o_pull_dn <= 1'b0;
            o_slow <= 1'b0;
            o_high <= 1'b0;
        end else begin
            o_out <= next_out;
            o_oe <= next_oe;
            o_pull_up <= next_pu;
            o_pull_dn <= next_pd;
            o_slow <= next_slow;
            o_high <= next_oe ? next_out : next_pu;
        end
    end
endmodule // pgp_pin_drive

// ===== hdl/pgp_port.v
`timescale 1ns/1ps
`include "pgp_defines.vh"

// Summary of operation
// - set code 0x22, read code 0x23
// - indexes 0-4 pins, 5-12 leds, rest none
// - set has two or three data bytes
// - duty 0 low, 1-99 pwm, 100 high
// - config bits: mode, function, reserved zero
// - modes 000 to 011 drive behaviour
// - modes 100, 101, 111 drive behaviour
// - mode 110 answers error, not applied
// - function bit only for pins 0-4
// - function zero ignores duty and mode
// - pins 1-3 default to host power roles
// - inputs sampled at 32 Hz, level kept
// - edge flags latched, cleared on read
// - status bits: level, falling, rising
// - read answer has four data bytes
// - config reserved bits read zero
// - set acknowledged with 0x62, length zero
// - pull-up switch reads open 1, closed 0
// - config saved to and restored from boot
module pgp_port #(
    parameter SAMP_W = 19,
    parameter P_SAMPLE_CYC = `PGP_SAMPLE_CYC,
    parameter STEP_W = 10,
    parameter P_PWM_STEP_CYC = `PGP_PWM_STEP_CYC
) (
    input wire i_sys_clk,
    input wire i_arst_n,
    input wire i_cmd_valid,
    input wire [7:0] i_cmd_code,
    input wire [7:0] i_cmd_len,
    input wire [7:0] i_cmd_d0,
    input wire [7:0] i_cmd_d1,
    input wire [7:0] i_cmd_d2,
    output reg o_rsp_valid,
    output reg [7:0] o_rsp_type,
    output reg [7:0] o_rsp_len,
    output reg [7:0] o_rsp_d0,
    output reg [7:0] o_rsp_d1,
    output reg [7:0] o_rsp_d2,
    output reg [7:0] o_rsp_d3,
    input wire [4:0] i_pin_in,
    output wire [4:0] o_pin_out,
    output wire [4:0] o_pin_oe,
    output wire [4:0] o_pin_pull_up,
    output wire [4:0] o_pin_pull_dn,
    output wire [4:0] o_pin_slow,
    output wire [7:0] o_led_output_line,
    input wire [4:0] i_dflt_oe,
    input wire [4:0] i_dflt_out,
    input wire i_store_boot,
    output reg o_save_valid,
    output reg [51:0] o_save_cfg,
    output reg [90:0] o_save_duty,
    input wire i_boot_valid,
    input wire [51:0] i_boot_cfg,
    input wire [90:0] i_boot_duty
);
    localparam integer L_SAMP_INT = P_SAMPLE_CYC - 1;
    localparam integer L_STEP_INT = P_PWM_STEP_CYC - 1;
    localparam [SAMP_W-1:0] L_SAMP_LAST = L_SAMP_INT[SAMP_W-1:0];
    localparam [STEP_W-1:0] L_STEP_LAST = L_STEP_INT[STEP_W-1:0];
    localparam [6:0] L_PCT_LAST = `PGP_DUTY_HIGH - 7'h01;

    reg [3:0] cfg [0:`PGP_NUM_PINS-1];
    reg [6:0] duty [0:`PGP_NUM_PINS-1];
    reg [4:0] samp;
    reg [4:0] rise_f;
    reg [4:0] fall_f;
    reg [SAMP_W-1:0] samp_cnt;
    reg [STEP_W-1:0] step_cnt;
    reg [6:0] pct_cnt;
    reg restore_pend;
    integer k;

    wire samp_tick;
    wire [12:0] lvl;
    wire [12:0] drv_high;
    wire [51:0] cfg_flat;
    wire [90:0] duty_flat;

    reg is_set;
    reg is_read;
    reg idx_ok;
    reg duty_ok;
    reg cfg_ok;
    reg set_ok;
    reg read_ok;
    reg [3:0] idx;
    reg [3:0] next_cfg;
    reg [12:0] rd_mask;
    reg [12:0] sts_s;
    reg [12:0] sts_r;
    reg [12:0] sts_f;
    reg len_val;
    reg len_cfg;
    reg [4:0] edge_r;
    reg [4:0] edge_f;
    reg [2:0] rd_sts;
    reg [6:0] rd_duty;
    reg [3:0] rd_cfg;
    reg next_rsp_valid;
    reg [7:0] next_rsp_type;
    reg [7:0] next_rsp_len;
    reg [7:0] next_rsp_d0;
    reg [7:0] next_rsp_d1;
    reg [7:0] next_rsp_d2;
    reg [7:0] next_rsp_d3;

    // command decode
    always @* begin
        idx = i_cmd_d0[3:0];
        is_set = i_cmd_valid && (i_cmd_code == `PGP_CMD_SET);
        is_read = i_cmd_valid && (i_cmd_code == `PGP_CMD_READ);
        idx_ok = (i_cmd_d0 < `PGP_IDX_LIMIT);
        duty_ok = (i_cmd_d1 <= `PGP_DUTY_MAX);
        // reserved nibble and mode 110 refused
        cfg_ok = (i_cmd_d2[7:4] == 4'h0) && (i_cmd_d2[2:0] != `PGP_MODE_RSVD);
        len_val = (i_cmd_len == `PGP_LEN_SET_VAL);
        len_cfg = (i_cmd_len == `PGP_LEN_SET_CFG);
        set_ok = is_set && idx_ok && duty_ok &&
                 (len_val || (len_cfg && cfg_ok));
        read_ok = is_read && idx_ok && (i_cmd_len == `PGP_LEN_READ);
        next_cfg = i_cmd_d2[3:0];
        if (i_cmd_d0 >= `PGP_NUM_GPIO) begin
            next_cfg[`PGP_CFG_F_BIT] = 1'b0;
        end
        rd_mask = 13'h0000;
        if (read_ok) begin
            rd_mask[idx] = 1'b1;
        end
    end

    // status views per index
    always @* begin
        sts_s = {lvl[12:5], samp};
        sts_r = {8'h00, rise_f};
        sts_f = {8'h00, fall_f};
        // edges seen at this tick, read-back of the addressed index
        edge_r = {5{samp_tick}} & i_pin_in & ~samp;
        edge_f = {5{samp_tick}} & ~i_pin_in & samp;
        rd_sts = {sts_r[idx], sts_f[idx], sts_s[idx]};
        rd_duty = duty[idx];
        rd_cfg = cfg[idx];
    end

    // configuration store, boot restore
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (k = 0; k < `PGP_NUM_PINS; k = k + 1) begin
                cfg[k] <= `PGP_RST_CFG_LED;
                duty[k] <= `PGP_RST_DUTY;
            end
            cfg[0] <= `PGP_RST_CFG_IN;
            cfg[1] <= `PGP_RST_CFG_IN; // power sense default
            cfg[2] <= `PGP_RST_CFG_CTL; // power control default
            cfg[3] <= `PGP_RST_CFG_CTL; // reset control default
            cfg[4] <= `PGP_RST_CFG_IN;
            restore_pend <= 1'b1;
        end else begin
            restore_pend <= 1'b0;
            if (restore_pend) begin
                if (i_boot_valid) begin
                    for (k = 0; k < `PGP_NUM_PINS; k = k + 1) begin
                        cfg[k] <= i_boot_cfg[k*4 +: 4];
                        duty[k] <= i_boot_duty[k*7 +: 7];
                    end
                end
            end else if (set_ok) begin
                duty[idx] <= i_cmd_d1[6:0];
                if (i_cmd_len == `PGP_LEN_SET_CFG) begin
                    cfg[idx] <= next_cfg;
                end
            end
        end
    end

    // boot state capture
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_save_valid <= 1'b0;
            o_save_cfg <= 52'h0;
            o_save_duty <= 91'h0;
        end else begin
            o_save_valid <= i_store_boot;
            if (i_store_boot) begin
                o_save_cfg <= cfg_flat;
                o_save_duty <= duty_flat;
            end
        end
    end

    // 32 Hz sample tick
    assign samp_tick = (samp_cnt == L_SAMP_LAST);

    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            samp_cnt <= {SAMP_W{1'b0}};
        end else if (samp_tick) begin
            samp_cnt <= {SAMP_W{1'b0}};
        end else begin
            samp_cnt <= samp_cnt + 1'b1;
        end
    end

    // sampled level and edge flags
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            samp <= 5'h00;
            rise_f <= 5'h00;
            fall_f <= 5'h00;
        end else begin
            if (samp_tick) begin
                samp <= i_pin_in; // pulled-up switch reads 1 open
            end
            // new edge in the read cycle wins over the clear
            rise_f <= (rise_f & ~rd_mask[4:0]) | edge_r;
            fall_f <= (fall_f & ~rd_mask[4:0]) | edge_f;
        end
    end

    // 100 Hz pwm, 100 steps
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            step_cnt <= {STEP_W{1'b0}};
            pct_cnt <= 7'h00;
        end else if (step_cnt == L_STEP_LAST) begin
            step_cnt <= {STEP_W{1'b0}};
            if (pct_cnt == L_PCT_LAST) begin
                pct_cnt <= 7'h00;
            end else begin
                pct_cnt <= pct_cnt + 7'h01;
            end
        end else begin
            step_cnt <= step_cnt + 1'b1;
        end
    end

    // response select, fields hold between answers
    always @* begin
        next_rsp_valid = (is_set || is_read) && !restore_pend;
        next_rsp_type = o_rsp_type;
        next_rsp_len = o_rsp_len;
        next_rsp_d0 = o_rsp_d0;
        next_rsp_d1 = o_rsp_d1;
        next_rsp_d2 = o_rsp_d2;
        next_rsp_d3 = o_rsp_d3;
        if (next_rsp_valid) begin
            next_rsp_len = `PGP_LEN_NONE;
            next_rsp_d0 = 8'h00;
            next_rsp_d1 = 8'h00;
            next_rsp_d2 = 8'h00;
            next_rsp_d3 = 8'h00;
            if (set_ok) begin
                next_rsp_type = i_cmd_code | `PGP_RSP_OK;
            end else if (read_ok) begin
                next_rsp_type = i_cmd_code | `PGP_RSP_OK;
                next_rsp_len = `PGP_LEN_READ_RSP;
                next_rsp_d0 = i_cmd_d0;
                next_rsp_d1 = {5'h00, rd_sts};
                next_rsp_d2 = {1'b0, rd_duty};
                next_rsp_d3 = {4'h0, rd_cfg};
            end else begin
                next_rsp_type = i_cmd_code | `PGP_RSP_ERR;
            end
        end
    end

    // response registers
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp_type <= 8'h00;
            o_rsp_len <= 8'h00;
            o_rsp_d0 <= 8'h00;
            o_rsp_d1 <= 8'h00;
            o_rsp_d2 <= 8'h00;
            o_rsp_d3 <= 8'h00;
        end else begin
            o_rsp_valid <= next_rsp_valid;
            o_rsp_type <= next_rsp_type;
            o_rsp_len <= next_rsp_len;
            o_rsp_d0 <= next_rsp_d0;
            o_rsp_d1 <= next_rsp_d1;
            o_rsp_d2 <= next_rsp_d2;
            o_rsp_d3 <= next_rsp_d3;
        end
    end

    // per pin level and drive
    genvar g;
    generate
        for (g = 0; g < `PGP_NUM_PINS; g = g + 1) begin : pin
            wire user_ctl;
            assign cfg_flat[g*4 +: 4] = cfg[g];
            assign duty_flat[g*7 +: 7] = duty[g];
            // full scale high, else compare
            assign lvl[g] = (duty[g] == `PGP_DUTY_HIGH) ||
                            ((duty[g] != 7'h00) && (pct_cnt < duty[g]));
            if (g < `PGP_NUM_GPIO) begin : gp
                assign user_ctl = cfg[g][`PGP_CFG_F_BIT];
                pgp_pin_drive u_drv (
                    .i_sys_clk(i_sys_clk),
                    .i_arst_n(i_arst_n),
                    .i_user(user_ctl),
                    .i_mode(cfg[g][2:0]),
                    .i_level(lvl[g]),
                    .i_dflt_oe(i_dflt_oe[g]),
                    .i_dflt_out(i_dflt_out[g]),
                    .o_out(o_pin_out[g]),
                    .o_oe(o_pin_oe[g]),
                    .o_pull_up(o_pin_pull_up[g]),
                    .o_pull_dn(o_pin_pull_dn[g]),
                    .o_slow(o_pin_slow[g]),
                    .o_high(drv_high[g])
                );
            end else begin : led
                assign user_ctl = 1'b1;
                pgp_pin_drive u_drv (
                    .i_sys_clk(i_sys_clk),
                    .i_arst_n(i_arst_n),
                    .i_user(user_ctl),
                    .i_mode(cfg[g][2:0]),
                    .i_level(lvl[g]),
                    .i_dflt_oe(1'b0),
                    .i_dflt_out(1'b0),
                    .o_out(),
                    .o_oe(),
                    .o_pull_up(),
                    .o_pull_dn(),
                    .o_slow(),
                    .o_high(drv_high[g])
                );
                assign o_led_output_line[g-`PGP_NUM_GPIO] = drv_high[g];
            end
        end
    endgenerate
endmodule // pgp_port

// ===== verif/pgp_host_model.sv
`timescale 1ns/1ps
// host side: one command, then holds off until the answer edge
module pgp_host_model (
    input wire i_sys_clk,
    output reg o_cmd_valid,
    output reg [7:0] o_cmd_code,
    output reg [7:0] o_cmd_len,
    output reg [7:0] o_cmd_d0,
    output reg [7:0] o_cmd_d1,
    output reg [7:0] o_cmd_d2
);
    initial begin
        {o_cmd_valid, o_cmd_code, o_cmd_len, o_cmd_d0, o_cmd_d1, o_cmd_d2} = 41'h0;
    end
    // codes and cfg 0-15 come from the caller; cfg 6/14 are refused only with length 3, with length 2 they are acknowledged
    task send(input [7:0] c, input [7:0] l, input [7:0] a, input [7:0] b, input [7:0] e);
        begin
            @(posedge i_sys_clk);
            o_cmd_valid <= 1'b1;
            o_cmd_code <= c;
            o_cmd_len <= l;
            {o_cmd_d0, o_cmd_d1, o_cmd_d2} <= {a, b, e};
            @(posedge i_sys_clk);
            o_cmd_valid <= 1'b0;
            {o_cmd_d0, o_cmd_d1, o_cmd_d2} <= ~{a, b, e};
            #1;
        end
    endtask
endmodule // pgp_host_model

// ===== verif/pgp_port_assertions.sv
`timescale 1ns/1ps
module pgp_port_assertions (
    input wire i_sys_clk,
    input wire i_arst_n,
    input wire i_cmd_valid,
    input wire [7:0] i_cmd_code,
    input wire [7:0] i_cmd_len,
    input wire [7:0] i_cmd_d0,
    input wire [7:0] i_cmd_d1,
    input wire [7:0] i_cmd_d2,
    input wire o_rsp_valid,
    input wire [7:0] o_rsp_type,
    input wire [7:0] o_rsp_len,
    input wire [7:0] o_rsp_d0,
    input wire [7:0] o_rsp_d1,
    input wire [7:0] o_rsp_d3,
    input wire [4:0] o_pin_oe,
    input wire [4:0] o_pin_pull_up,
    input wire [4:0] o_pin_pull_dn,
    input wire i_store_boot,
    input wire o_save_valid
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_cmd;
        i_cmd_valid && (i_cmd_code == 8'h22 || i_cmd_code == 8'h23);
    endsequence
    sequence s_set;
        i_cmd_valid && i_cmd_code == 8'h22;
    endsequence
    sequence s_set_ok;
        s_set ##0 (i_cmd_d0 < 8'h0D && i_cmd_d1 <= 8'h64 && (i_cmd_len == 8'h02 ||
            (i_cmd_len == 8'h03 && i_cmd_d2[7:4] == 4'h0 && i_cmd_d2[2:0] != 3'h6)));
    endsequence
    sequence s_read_ok;
        i_cmd_valid && i_cmd_code == 8'h23 && i_cmd_len == 8'h01 && i_cmd_d0 < 8'h0D;
    endsequence
    a_cmd_answer: assert property (s_cmd |=> o_rsp_valid)
        else $error("command not answered");
    a_no_answer: assert property (!(i_cmd_valid && (i_cmd_code == 8'h22 ||
        i_cmd_code == 8'h23)) |=> !o_rsp_valid)
        else $error("answer without command");
    a_set_ack: assert property (s_set_ok |=> o_rsp_type == 8'h62 && o_rsp_len == 8'h00)
        else $error("set not acknowledged");
    a_set_err: assert property (s_set ##0 (i_cmd_d0 > 8'h0C || i_cmd_d1 > 8'h64) |=>
        o_rsp_type == 8'hE2) else $error("bad set not refused");
    a_rsvd_mode: assert property (s_set ##0 (i_cmd_len == 8'h03 && i_cmd_d2[2:0] == 3'h6)
        |=> o_rsp_type == 8'hE2) else $error("reserved mode not refused");
    a_read_form: assert property (s_read_ok |=> o_rsp_type == 8'h63 && o_rsp_len == 8'h04 &&
        o_rsp_d0 == $past(i_cmd_d0) && o_rsp_d1[7:3] == 5'h0 && o_rsp_d3[7:4] == 4'h0)
        else $error("read answer malformed");
    a_save_pulse: assert property (i_store_boot |=> o_save_valid ##1 !o_save_valid)
        else $error("save image not pulsed");
    a_drive_excl: assert property (((o_pin_oe | o_pin_pull_dn) & o_pin_pull_up) == 5'h0 &&
        (o_pin_oe & o_pin_pull_dn) == 5'h0) else $error("pin drive conflict");
endmodule // pgp_port_assertions
bind pgp_port pgp_port_assertions u_pgp_port_assertions (.i_sys_clk, .i_arst_n, .i_cmd_valid,
    .i_cmd_code, .i_cmd_len, .i_cmd_d0, .i_cmd_d1, .i_cmd_d2, .o_rsp_valid, .o_rsp_type,
    .o_rsp_len, .o_rsp_d0, .o_rsp_d1, .o_rsp_d3, .o_pin_oe, .o_pin_pull_up, .o_pin_pull_dn,
    .i_store_boot, .o_save_valid);

// ===== verif/pgp_port_tb.sv
`timescale 1ns/1ps
module pgp_port_tb;
    reg i_sys_clk = 1'b0;
    reg i_arst_n, i_store_boot, i_boot_valid;
    reg [4:0] i_dflt_oe, i_dflt_out, sw;
    reg [4:0] flt = 5'h00;
    reg [51:0] i_boot_cfg;
    reg [90:0] i_boot_duty;
    wire i_cmd_valid, o_rsp_valid, o_save_valid;
    wire [7:0] i_cmd_code, i_cmd_len, i_cmd_d0, i_cmd_d1, i_cmd_d2, o_rsp_type, o_rsp_len;
    wire [7:0] o_rsp_d0, o_rsp_d1, o_rsp_d2, o_rsp_d3, o_led_output_line;
    wire [4:0] i_pin_in, o_pin_out, o_pin_oe, o_pin_pull_up, o_pin_pull_dn, o_pin_slow;
    wire [51:0] o_save_cfg;
    wire [90:0] o_save_duty;
    integer error_cnt = 0;
    integer comparisons = 0;
    integer i, k, n;
    reg [31:0] rnd;
    reg [7:0] ex, du;
    reg [2:0] drv;
    reg [3:0] m_cfg [0:12];
    reg [7:0] m_duty [0:12];
    pgp_port #(.P_SAMPLE_CYC(16), .P_PWM_STEP_CYC(2)) u_pgp_port (.i_sys_clk, .i_arst_n,
        .i_cmd_valid, .i_cmd_code, .i_cmd_len, .i_cmd_d0, .i_cmd_d1, .i_cmd_d2, .o_rsp_valid,
        .o_rsp_type, .o_rsp_len, .o_rsp_d0, .o_rsp_d1, .o_rsp_d2, .o_rsp_d3, .i_pin_in,
        .o_pin_out, .o_pin_oe, .o_pin_pull_up, .o_pin_pull_dn, .o_pin_slow, .o_led_output_line,
        .i_dflt_oe, .i_dflt_out, .i_store_boot, .o_save_valid, .o_save_cfg, .o_save_duty,
        .i_boot_valid, .i_boot_cfg, .i_boot_duty);
    pgp_host_model u_pgp_host_model (.i_sys_clk, .o_cmd_valid(i_cmd_valid),
        .o_cmd_code(i_cmd_code), .o_cmd_len(i_cmd_len), .o_cmd_d0(i_cmd_d0),
        .o_cmd_d1(i_cmd_d1), .o_cmd_d2(i_cmd_d2));
    // pin wire: switch to ground wins, else drive, pull, or a toggling float
    assign i_pin_in = ~sw & ((o_pin_oe & o_pin_out) |
        (~o_pin_oe & (o_pin_pull_up | (~o_pin_pull_dn & flt))));
    initial forever #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) flt <= ~flt;
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task finish_test;
        begin
            $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
            if (error_cnt == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task send(input [7:0] c, input [7:0] l, input [7:0] a, input [7:0] b, input [7:0] e);
        begin
            u_pgp_host_model.send(c, l, a, b, e);
            chk("answer", 8'h01, {7'h0, o_rsp_valid});
        end
    endtask
    task do_set(input [7:0] a, input [7:0] b, input [7:0] c, input [7:0] l);
        begin
            ex = (a > 8'h0C || b > 8'h64 || (l == 8'h03 && c[2:0] == 3'h6)) ? 8'hE2 : 8'h62;
            send(8'h22, l, a, b, c);
            chk("set_type", ex, o_rsp_type);
            chk("set_len", 8'h00, o_rsp_len);
            if (ex == 8'h62) begin
                m_duty[a] = b;
                if (l == 8'h03)
                    m_cfg[a] = (a < 8'h05) ? c[3:0] : {1'b0, c[2:0]};
            end
        end
    endtask
    task do_read(input [7:0] a);
        begin
            send(8'h23, 8'h01, a, 8'h00, 8'h00);
            chk("rd_type", (a > 8'h0C) ? 8'hE3 : 8'h63, o_rsp_type);
            if (a < 8'h0D) begin
                chk("rd_len", 8'h04, o_rsp_len);
                chk("rd_idx", a, o_rsp_d0);
                chk("rd_duty", m_duty[a], o_rsp_d2);
                chk("rd_cfg", {4'h0, m_cfg[a]}, o_rsp_d3);
            end
        end
    endtask
    task rst;
        begin
            @(posedge i_sys_clk);
            i_arst_n <= 1'b0;
            repeat (6) @(posedge i_sys_clk);
            i_arst_n <= 1'b1;
            repeat (3) @(posedge i_sys_clk);
            for (k = 0; k < 13; k = k + 1) begin
                m_cfg[k] = (k < 5 && k != 2 && k != 3) ? 4'h2 : 4'h1;
                m_duty[k] = 8'h00;
            end
        end
    endtask
    function [2:0] exp_drv(input [2:0] m, input h);
        case (m)
            3'h0: exp_drv = h ? 3'h4 : 3'h1;
            3'h1, 3'h5: exp_drv = 3'h4;
            3'h3: exp_drv = h ? 3'h2 : 3'h4;
            3'h4: exp_drv = {h, 2'h0};
            3'h7: exp_drv = {~h, 2'h0};
            default: exp_drv = 3'h0;
        endcase
    endfunction
    initial begin
        #9000000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
    initial begin
        {i_arst_n, i_store_boot, i_boot_valid, sw, i_boot_cfg, i_boot_duty} = 151'h0;
        rnd = $urandom(34);
        rnd = $urandom;
        {i_dflt_oe, i_dflt_out} = rnd[9:0];
        rst;
        do_read(8'h02);
        chk("dflt_oe", {3'h0, i_dflt_oe}, {3'h0, o_pin_oe});
        for (i = 0; i < 60; i = i + 1) begin
            rnd = $urandom;
            do_set({3'h0, rnd[4:0]}, {1'b0, rnd[14:8]}, {4'h0, rnd[19:16]}, rnd[20] ? 8'h03 : 8'h02);
            do_read({3'h0, rnd[4:0]});
        end
        do_set(8'hFF, 8'h00, 8'h00, 8'h02);
        do_set(8'h00, 8'h65, 8'h00, 8'h02);
        send(8'h22, 8'h04, 8'h00, 8'h00, 8'h01);
        chk("len_err", 8'hE2, o_rsp_type);
        for (i = 0; i < 16; i = i + 1) begin
            do_set(8'h00, i[0] ? 8'h64 : 8'h00, {5'h1, i[3:1]}, 8'h03);
            repeat (3) @(posedge i_sys_clk);
            drv = exp_drv(i[3:1], i[0]);
            if (i[3:1] != 3'h6) begin
                chk("drive", {5'h0, drv}, {5'h0, o_pin_oe[0], o_pin_pull_up[0], o_pin_pull_dn[0]});
                chk("slow", {7'h0, i[3]}, {7'h0, o_pin_slow[0]});
                if (drv[2])
                    chk("out", {7'h0, i[0]}, {7'h0, o_pin_out[0]});
            end
        end
        do_set(8'h02, 8'h64, 8'h05, 8'h03);
        repeat (3) @(posedge i_sys_clk);
        chk("f0_oe", {7'h0, i_dflt_oe[2]}, {7'h0, o_pin_oe[2]});
        do_set(8'h04, 8'h64, 8'h0B, 8'h03);
        repeat (40) @(posedge i_sys_clk);
        do_read(8'h04);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge i_sys_clk);
            sw <= (i == 3) ? 5'h00 : {i[0] ^ 1'b1, 4'h0};
            repeat (40) @(posedge i_sys_clk);
            if (i != 1)
                do_read(8'h04);
            ex = (i == 0) ? 8'h02 : (i == 2) ? 8'h06 : 8'h05;
            if (i != 1)
                chk("status", ex, o_rsp_d1);
        end
        do_read(8'h04);
        chk("status", 8'h01, o_rsp_d1);
        for (i = 0; i < 3; i = i + 1) begin
            du = (i == 0) ? 8'h00 : (i == 1) ? 8'h1E : 8'h64;
            do_set(8'h05, du, 8'h01, 8'h03);
            repeat (4) @(posedge i_sys_clk);
            n = 0;
            for (k = 0; k < 200; k = k + 1) begin
                @(negedge i_sys_clk);
                n = n + o_led_output_line[0];
            end
            chk("pwm_hi", du * 8'h02, n[7:0]);
        end
        @(posedge i_sys_clk);
        i_store_boot <= 1'b1;
        @(posedge i_sys_clk);
        i_store_boot <= 1'b0;
        #1;
        chk("save_vld", 8'h01, {7'h0, o_save_valid});
        chk("save_cfg", {4'h0, m_cfg[4]}, {4'h0, o_save_cfg[19:16]});
        chk("sv_duty", m_duty[4], {1'b0, o_save_duty[34:28]});
        @(posedge i_sys_clk);
        i_boot_valid <= 1'b1;
        i_boot_cfg <= {13{4'hB}};
        i_boot_duty <= {13{7'h2A}};
        rst;
        m_cfg[0] = 4'hB;
        m_duty[0] = 8'h2A;
        do_read(8'h00);
        finish_test;
    end
endmodule // pgp_port_tb
